// file: eeprom_pkg.sv
// Purpose: Shared constants for the two-wire serial memory front end
// Assumes: 100 MHz system clock, serial clock and data sampled as plain inputs
// Notes: Write cycle time is a parameter default of the top module
package eeprom_pkg;
  localparam int ADDR_W = 13;
  localparam int MEM_BYTES = 8192;
  localparam int ID_BYTES = 32;
  localparam int ID_ADDR_W = 5;
  localparam logic [3:0] TYPE_ARRAY = 4'hA;
  localparam logic [3:0] TYPE_ID = 4'hB;
  localparam logic [2:0] SEL_FIXED_5BALL = 3'h1;
  localparam logic [3:0] BIT_CNT_ACK = 4'h8;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_CYCLE_TIME_US = 5000;
  localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int ID_LOCK_ADDR_BIT = 10;
  localparam logic ID_UNLOCKED = 1'b0;
  localparam int BUF_DEPTH = 2;
  localparam int BUF_W = 8;
endpackage

// file: byte_buffer.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock domain, synchronous active-high reset
// Notes: Full and empty are exact; a full buffer drops ready to the source
`timescale 1ns/100ps
module byte_buffer (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [eeprom_pkg::BUF_W-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [eeprom_pkg::BUF_W-1:0] out_data_o,
  input wire logic out_ready_i
);
  logic [eeprom_pkg::BUF_W-1:0] mem_reg [eeprom_pkg::BUF_DEPTH];
  logic [eeprom_pkg::BUF_W-1:0] mem_next [eeprom_pkg::BUF_DEPTH];
  logic wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [1:0] count_reg, count_next;
  logic push, pop;

  always_comb begin
    push = in_valid_i && (count_reg != 2'h2);
    pop = out_ready_i && (count_reg != 2'h0);
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_data_i;
      wr_ptr_next = ~wr_ptr_reg;
    end
    if (pop) begin
      rd_ptr_next = ~rd_ptr_reg;
    end
    if (push && !pop) begin
      count_next = count_reg + 2'h1;
    end else if (pop && !push) begin
      count_next = count_reg - 2'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
      mem_reg[0] <= 8'h00;
      mem_reg[1] <= 8'h00;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      mem_reg <= mem_next;
    end
  end

  assign in_ready_o = (count_reg != 2'h2);
  assign out_valid_o = (count_reg != 2'h0);
  assign out_data_o = mem_reg[rd_ptr_reg];
endmodule

// file: eeprom_select_write_protect.sv
// Purpose: Two-wire serial memory slave with select match and write protect
// Assumes: Serial clock and data are slow pins sampled by clock_i
// Notes: reset_i stands for the power-on reset; no other reset exists
// Operation
// RULE_01 - Memory holds 8192 bytes, 64 kilobits in all.
// RULE_02 - A separate 32-byte identification page, lockable to read-only; the code never sets the lock, so the page stays unlocked.
// RULE_03 - Select code bits b3..b1 compare against the three select pins.
// RULE_04 - An unconnected select pin reads as 0.
// RULE_05 - Five-ball option fixes the select pins to 0,0,1.
// RULE_06 - Write protect high keeps every memory location unchanged.
// RULE_07 - Write protect low or floating allows writes.
// RULE_08 - Protected: select and address acknowledged, data bytes not.
// RULE_09 - Data line is open drain: pulled low or released only.
// RULE_10 - Serial clock samples incoming data and times outgoing data.
// RULE_11 - Bus ignored until power-on reset releases, then standby.
// RULE_12 - Power-on reset asserted again stops all bus response.
// RULE_13 - Stop condition enters standby unless a write cycle runs.
// RULE_14 - Last select bit 1 means read, 0 means write.
// RULE_15 - Match acknowledges in the ninth slot; mismatch releases, standby.
// RULE_16 - During a write cycle the output is off and requests ignored.
// RULE_17 - Write protect sampled per data byte before its acknowledge.
// RULE_18 - All bus state idle, line released, while power-on reset holds.
`timescale 1ns/100ps
module eeprom_select_write_protect #(
  parameter int WRITE_CYCLE_CYCLES = eeprom_pkg::WRITE_CYCLE_CYCLES,
  parameter bit FIVE_BALL = 1'b0
) (
  // Clock and power-on reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Straps, floating pins arrive as 0
  input wire logic slave_select_hi_i,
  input wire logic slave_select_mid_i,
  input wire logic slave_select_lo_i,
  input wire logic write_protect_pin_i,
  // Status
  output logic write_busy_o
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_SEL, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA, ST_RDATA, ST_RACK
  } phase_e;

  logic [2:0] scl_sync_reg, sda_sync_reg;
  logic [1:0] wp_sync_reg;
  logic [1:0] sel_sync_reg [3];
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [2:0] sel_pins;

  phase_e phase_reg, phase_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [12:0] addr_reg, addr_next;
  logic [7:0] addr_hi_reg, addr_hi_next;
  logic in_ack_reg, in_ack_next;
  logic ack_drive_reg, ack_drive_next;
  logic drive_low_reg, drive_low_next;
  logic id_sel_reg, id_sel_next;
  logic wp_byte_reg, wp_byte_next;
  logic wr_pend_reg, wr_pend_next;
  logic id_locked_reg, id_locked_next;
  logic [31:0] busy_cnt_reg, busy_cnt_next;
  logic [7:0] rd_byte;

  logic [7:0] mem [eeprom_pkg::MEM_BYTES]; // RULE_01
  logic [7:0] id_mem [eeprom_pkg::ID_BYTES]; // RULE_02

  logic buf_in_valid, buf_in_ready, buf_out_valid, buf_pop;
  logic [7:0] buf_out_data;
  logic [12:0] wr_addr_reg, wr_addr_next;
  logic wr_id_reg, wr_id_next;

  // Three flops on clock and data, two on each strap; edges found from the second and third stages
  always_ff @(posedge clock_i) begin
    scl_sync_reg <= {scl_sync_reg[1:0], scl_i}; // RULE_10
    sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
    wp_sync_reg <= {wp_sync_reg[0], write_protect_pin_i};
    sel_sync_reg[0] <= {sel_sync_reg[0][0], slave_select_lo_i};
    sel_sync_reg[1] <= {sel_sync_reg[1][0], slave_select_mid_i};
    sel_sync_reg[2] <= {sel_sync_reg[2][0], slave_select_hi_i};
  end

  always_comb begin
    scl_rise = scl_sync_reg[1] && !scl_sync_reg[2];
    scl_fall = !scl_sync_reg[1] && scl_sync_reg[2];
    start_det = scl_sync_reg[1] && scl_sync_reg[2] && !sda_sync_reg[1] && sda_sync_reg[2];
    stop_det = scl_sync_reg[1] && scl_sync_reg[2] && sda_sync_reg[1] && !sda_sync_reg[2];
    sel_pins = FIVE_BALL ? eeprom_pkg::SEL_FIXED_5BALL // RULE_05
      : {sel_sync_reg[2][1], sel_sync_reg[1][1], sel_sync_reg[0][1]}; // RULE_04
    rd_byte = id_sel_reg ? id_mem[addr_reg[eeprom_pkg::ID_ADDR_W-1:0]] : mem[addr_reg];
  end

  always_comb begin
    phase_next = phase_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    addr_next = addr_reg;
    addr_hi_next = addr_hi_reg;
    in_ack_next = in_ack_reg;
    ack_drive_next = ack_drive_reg;
    drive_low_next = drive_low_reg;
    id_sel_next = id_sel_reg;
    wp_byte_next = wp_byte_reg;
    wr_pend_next = wr_pend_reg;
    busy_cnt_next = busy_cnt_reg;
    buf_in_valid = 1'b0;
    if (busy_cnt_reg != 32'h0) begin
      // Internal write cycle: line off, bus ignored
      busy_cnt_next = busy_cnt_reg - 32'h1; // RULE_16
      phase_next = ST_IDLE;
      drive_low_next = 1'b0; // RULE_16
      if (busy_cnt_reg == 32'h1) begin
        addr_next = addr_reg + 13'h1;
      end
    end else if (stop_det) begin
      phase_next = ST_IDLE; // RULE_13
      drive_low_next = 1'b0;
      in_ack_next = 1'b0;
      if (wr_pend_reg) begin
        busy_cnt_next = WRITE_CYCLE_CYCLES;
        wr_pend_next = 1'b0;
      end
    end else if (start_det) begin
      phase_next = ST_SEL;
      bit_cnt_next = eeprom_pkg::BIT_CNT_RESET;
      in_ack_next = 1'b0;
      drive_low_next = 1'b0;
      wr_pend_next = 1'b0;
    end else if (phase_reg != ST_IDLE && scl_rise) begin
      if (!in_ack_reg) begin
        // Outgoing read data shifts on the falling edge only
        if (phase_reg != ST_RDATA) begin
          shift_next = {shift_reg[6:0], sda_sync_reg[1]};
        end
        bit_cnt_next = bit_cnt_reg + 4'h1; // RULE_10
        if (bit_cnt_reg == 4'h7) begin
          wp_byte_next = wp_sync_reg[1]; // RULE_17
        end
      end else if (phase_reg == ST_RDATA && sda_sync_reg[1]) begin
        phase_next = ST_IDLE;
      end
    end else if (phase_reg != ST_IDLE && scl_fall) begin
      if (!in_ack_reg && bit_cnt_reg == eeprom_pkg::BIT_CNT_ACK) begin
        in_ack_next = 1'b1;
        bit_cnt_next = eeprom_pkg::BIT_CNT_RESET;
        ack_drive_next = 1'b1;
        case (phase_reg)
          ST_SEL: begin
            if ((shift_reg[7:4] == eeprom_pkg::TYPE_ARRAY || shift_reg[7:4] == eeprom_pkg::TYPE_ID)
                && shift_reg[3:1] == sel_pins) begin // RULE_03
              id_sel_next = (shift_reg[7:4] == eeprom_pkg::TYPE_ID);
              phase_next = shift_reg[0] ? ST_RDATA : ST_ADDR_HI; // RULE_14
            end else begin
              phase_next = ST_IDLE; // RULE_15
              ack_drive_next = 1'b0;
              in_ack_next = 1'b0;
            end
          end
          ST_ADDR_HI: begin
            addr_hi_next = shift_reg; // RULE_08
            phase_next = ST_ADDR_LO;
          end
          ST_ADDR_LO: begin
            addr_next = {addr_hi_reg[4:0], shift_reg};
            phase_next = ST_WDATA;
          end
          ST_WDATA: begin
            if (wp_byte_reg || (id_sel_reg && id_locked_reg) || !buf_in_ready) begin
              ack_drive_next = 1'b0; // RULE_08
            end else begin
              buf_in_valid = 1'b1; // RULE_07
              wr_pend_next = 1'b1;
            end
          end
          ST_RDATA: begin
            phase_next = ST_RDATA; // RULE_10
          end
          default: begin
            phase_next = ST_IDLE;
          end
        endcase
        drive_low_next = ack_drive_next && (phase_reg != ST_RDATA); // RULE_15
        if (phase_reg == ST_RDATA) begin
          drive_low_next = 1'b0;
          in_ack_next = 1'b1;
          addr_next = addr_reg + 13'h1;
        end
      end else if (in_ack_reg) begin
        in_ack_next = 1'b0;
        drive_low_next = (phase_reg == ST_RDATA) ? !rd_byte[7] : 1'b0; // RULE_10
        if (phase_reg == ST_RDATA) begin
          shift_next = {rd_byte[6:0], 1'b0};
          bit_cnt_next = eeprom_pkg::BIT_CNT_RESET;
        end
      end else if (phase_reg == ST_RDATA) begin
        drive_low_next = (bit_cnt_reg == 4'h8) ? 1'b0 : !shift_reg[7];
        shift_next = {shift_reg[6:0], 1'b0};
        if (bit_cnt_reg == 4'h8) begin
          bit_cnt_next = eeprom_pkg::BIT_CNT_ACK;
        end
      end
    end
  end

  // Buffer drains into the array; a held write-protect level blocks the store
  always_comb begin
    buf_pop = buf_out_valid;
    wr_addr_next = wr_addr_reg;
    wr_id_next = wr_id_reg;
    id_locked_next = id_locked_reg;
    if (buf_in_valid) begin
      wr_addr_next = addr_reg;
      wr_id_next = id_sel_reg;
    end
  end

  always_ff @(posedge clock_i) begin
    if (buf_pop && !wp_sync_reg[1]) begin // RULE_06
      if (wr_id_reg) begin
        id_mem[wr_addr_reg[eeprom_pkg::ID_ADDR_W-1:0]] <= buf_out_data;
      end else begin
        mem[wr_addr_reg] <= buf_out_data;
      end
    end
  end

  byte_buffer u_buf (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .in_valid_i(buf_in_valid),
    .in_data_i(shift_reg),
    .in_ready_o(buf_in_ready),
    .out_valid_o(buf_out_valid),
    .out_data_o(buf_out_data),
    .out_ready_i(buf_pop)
  );

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      phase_reg <= ST_IDLE; // RULE_11 RULE_12 RULE_18
      bit_cnt_reg <= eeprom_pkg::BIT_CNT_RESET;
      shift_reg <= 8'h00;
      addr_reg <= 13'h0000;
      addr_hi_reg <= 8'h00;
      in_ack_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
      drive_low_reg <= 1'b0; // RULE_18
      id_sel_reg <= 1'b0;
      wp_byte_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      id_locked_reg <= eeprom_pkg::ID_UNLOCKED;
      busy_cnt_reg <= 32'h0;
      wr_addr_reg <= 13'h0000;
      wr_id_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      addr_reg <= addr_next;
      addr_hi_reg <= addr_hi_next;
      in_ack_reg <= in_ack_next;
      ack_drive_reg <= ack_drive_next;
      drive_low_reg <= drive_low_next;
      id_sel_reg <= id_sel_next;
      wp_byte_reg <= wp_byte_next;
      wr_pend_reg <= wr_pend_next;
      id_locked_reg <= id_locked_next;
      busy_cnt_reg <= busy_cnt_next;
      wr_addr_reg <= wr_addr_next;
      wr_id_reg <= wr_id_next;
    end
  end

  // Open drain: data out is always 0, enable low only while pulling
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sda_o <= 1'b0;
      sda_oe_n_o <= 1'b1;
      write_busy_o <= 1'b0;
    end else begin
      sda_o <= 1'b0; // RULE_09
      sda_oe_n_o <= !drive_low_next; // RULE_09
      write_busy_o <= (busy_cnt_next != 32'h0);
    end
  end
endmodule

// file: eeprom_monitor.sv
// Purpose: Port checker for the serial memory front end
// Assumes: One clock domain, synchronous active-high power-on reset
// Notes: Bound to the top module below
`timescale 1ns/100ps
module eeprom_monitor #(
  parameter int WRITE_CYCLE_CYCLES = 50
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  // Straps and status
  input wire logic slave_select_hi_i,
  input wire logic slave_select_mid_i,
  input wire logic slave_select_lo_i,
  input wire logic write_protect_pin_i,
  input wire logic write_busy_o
);
  int busy_cnt_reg;
  int busy_cnt_next;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  always_comb begin
    busy_cnt_next = write_busy_o ? busy_cnt_reg + 1 : 0;
  end
  always_ff @(posedge clock_i) begin
    busy_cnt_reg <= reset_i ? 0 : busy_cnt_next;
  end
  AST_RESET_IDLE: assert property (disable iff (1'b0) reset_i |=> sda_oe_n_o && !write_busy_o)
    else $error("bus state not idle after reset");
  AST_OPEN_DRAIN: assert property (!sda_o)
    else $error("data line driven high");
  AST_BUSY_SILENT: assert property (write_busy_o |-> sda_oe_n_o)
    else $error("data line pulled during write cycle");
  AST_BUSY_LEN: assert property ($fell(write_busy_o) |->
    busy_cnt_reg inside {[WRITE_CYCLE_CYCLES-1:WRITE_CYCLE_CYCLES+1]})
    else $error("write cycle length wrong");
  AST_PULL_SCL_LOW: assert property ($fell(sda_oe_n_o) |-> !scl_i)
    else $error("pull started with clock high");
  AST_RELEASE_SCL_LOW: assert property ($rose(sda_oe_n_o) |-> !scl_i)
    else $error("release with clock high");
  AST_ACK_HELD: assert property ($fell(sda_oe_n_o) |=> !sda_oe_n_o [*8])
    else $error("acknowledge too short");
  AST_WRITE_AFTER_STOP: assert property ($rose(write_busy_o) |-> scl_i && sda_i)
    else $error("write cycle without stop");
  AST_PROTECT_NO_WRITE: assert property ($rose(write_busy_o) |-> !write_protect_pin_i)
    else $error("write cycle while protected");
  COV_ACK: cover property ($fell(sda_oe_n_o));
  COV_WRITE: cover property ($rose(write_busy_o));
  COV_PROT_ACK: cover property (write_protect_pin_i && $fell(sda_oe_n_o));
endmodule

bind eeprom_select_write_protect eeprom_monitor #(
  .WRITE_CYCLE_CYCLES(WRITE_CYCLE_CYCLES)
) u_eeprom_monitor (
  .clock_i(clock_i),
  .reset_i(reset_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o),
  .slave_select_hi_i(slave_select_hi_i),
  .slave_select_mid_i(slave_select_mid_i),
  .slave_select_lo_i(slave_select_lo_i),
  .write_protect_pin_i(write_protect_pin_i),
  .write_busy_o(write_busy_o)
);

// file: i2c_master_model.sv
// Purpose: Behavioural two-wire bus master
// Assumes: Line has a pull-up; clock period averages 12.5 system cycles
// Notes: Reports the level seen in every ninth slot
`timescale 1ns/100ps
module i2c_master_model (
  // Clock
  input wire logic clock_i,
  // Bus wire
  input wire logic sda_line_i,
  output logic scl_o,
  output logic sda_o,
  // Ninth slot report
  output logic ack_valid_o,
  output logic ack_seen_o,
  output logic [7:0] rx_byte_o
);
  logic odd = 1'b0;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    ack_valid_o = 1'b0;
    ack_seen_o = 1'b0;
    rx_byte_o = 8'h00;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // Data changes only while the clock is low
  task automatic bit_slot(input logic b, output logic s);
    wait_clk(3);
    sda_o <= b;
    wait_clk(3);
    scl_o <= 1'b1;
    wait_clk(6 + int'(odd));
    s = sda_line_i;
    scl_o <= 1'b0;
    odd = ~odd;
  endtask
  task automatic start();
    wait_clk(3);
    sda_o <= 1'b1;
    wait_clk(3);
    scl_o <= 1'b1;
    wait_clk(6);
    sda_o <= 1'b0;
    wait_clk(6);
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    wait_clk(3);
    sda_o <= 1'b0;
    wait_clk(3);
    scl_o <= 1'b1;
    wait_clk(6);
    sda_o <= 1'b1;
    wait_clk(6);
  endtask
  // Sending 8'hFF releases the line so a read byte shows; nine is the ninth-slot level
  task automatic byte_tx(input logic [7:0] d, input logic nine);
    logic s;
    logic [7:0] r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i], s);
      r[i] = s;
    end
    rx_byte_o <= r;
    bit_slot(nine, s);
    ack_seen_o <= ~s;
    ack_valid_o <= 1'b1;
    wait_clk(1);
    ack_valid_o <= 1'b0;
  endtask
endmodule

// file: tb.sv
// Purpose: Self-checking bench for the serial memory front end
// Assumes: Write cycle shortened to 400 clocks
// Notes: Acknowledge notes are queued by the driver, checked by a watcher
`timescale 1ns/100ps
module tb;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic scl;
  logic sda_m;
  logic sda_o;
  logic sda_oe_n_o;
  logic busy;
  logic ack_valid;
  logic ack_seen;
  logic wp = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [2:0] code;
  logic [7:0] rx_byte;
  logic [7:0] d1;
  logic [12:0] adr;
  logic oe_n_fix;
  logic [9:0] exp_head;
  // Entry: read-data flag, expected acknowledge seen (ninth-slot level low), expected read byte
  logic [9:0] exp_q[$];
  int errors = 0;
  int n_checks = 0;
  integer seed = 32'hAFE5D99C;
  wire sda_line = sda_m & (sda_oe_n_o | sda_o) & oe_n_fix;
  eeprom_select_write_protect #(.WRITE_CYCLE_CYCLES(400), .FIVE_BALL(1'b0))
    u_eeprom_select_write_protect (
    .clock_i(clock_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .slave_select_hi_i(sel[2]), .slave_select_mid_i(sel[1]),
    .slave_select_lo_i(sel[0]), .write_protect_pin_i(wp), .write_busy_o(busy));
  // Second device with fixed straps on the same wire answers only to select code 001
  eeprom_select_write_protect #(.WRITE_CYCLE_CYCLES(400), .FIVE_BALL(1'b1))
    u_eeprom_select_write_protect_fixed (
    .clock_i(clock_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda_line), .sda_o(),
    .sda_oe_n_o(oe_n_fix), .slave_select_hi_i(sel[2]), .slave_select_mid_i(sel[1]),
    .slave_select_lo_i(sel[0]), .write_protect_pin_i(wp), .write_busy_o());
  i2c_master_model u_i2c_master_model (.clock_i(clock_i), .sda_line_i(sda_line), .scl_o(scl),
    .sda_o(sda_m), .ack_valid_o(ack_valid), .ack_seen_o(ack_seen), .rx_byte_o(rx_byte));
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  task automatic check_bit(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tx(input logic [7:0] d, input logic e);
    exp_q.push_back({1'b0, e, 8'h00});
    u_i2c_master_model.byte_tx(d, 1'b1);
  endtask
  // Read one byte; last gives NoAck, otherwise the master acknowledges
  task automatic rx(input logic [7:0] d, input logic last);
    exp_q.push_back({1'b1, !last, d});
    u_i2c_master_model.byte_tx(8'hFF, last);
  endtask
  task automatic address(input logic [12:0] a);
    u_i2c_master_model.start();
    tx({4'hA, sel, 1'b0}, 1'b1);
    tx({3'h0, a[12:8]}, 1'b1);
    tx(a[7:0], 1'b1);
  endtask
  task automatic write_frame(input logic [12:0] a, input logic [7:0] d, input logic e);
    address(a);
    tx(d, e);
  endtask
  always @(posedge clock_i) begin
    if (ack_valid === 1'b1) begin
      exp_head = exp_q.pop_front();
      check_bit("ack", exp_head[8], ack_seen);
      if (exp_head[9]) check_byte("read data", exp_head[7:0], rx_byte);
    end
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    for (int k = 0; k < 8; k++) begin
      sel <= 3'($random(seed));
      code = 3'($random(seed));
      @(posedge clock_i);
      if (k[0] == 1'b0) code = sel;
      if (k == 1) code = 3'h1;
      u_i2c_master_model.start();
      tx({3'h5, k[1], code, 1'b0}, (code == sel) || (code == 3'h1));
      u_i2c_master_model.stop();
      check_bit("busy", 1'b0, busy);
    end
    d1 = 8'($random(seed));
    adr = 13'($random(seed));
    write_frame(adr, d1, 1'b1);
    u_i2c_master_model.stop();
    check_bit("busy", 1'b1, busy);
    u_i2c_master_model.start();
    tx({4'hA, sel, 1'b0}, 1'b0);
    u_i2c_master_model.stop();
    for (int w = 0; w < 600 && busy !== 1'b0; w++) @(posedge clock_i);
    check_bit("busy", 1'b0, busy);
    repeat (4) @(posedge clock_i);
    wp <= 1'b1;
    write_frame(adr, 8'h5A, 1'b0);
    tx(8'hA5, 1'b0);
    u_i2c_master_model.stop();
    check_bit("busy", 1'b0, busy);
    write_frame(adr + 13'h1, 8'h3C, 1'b0);
    wp <= 1'b0;
    tx(8'hC3, 1'b1);
    u_i2c_master_model.stop();
    check_bit("busy", 1'b1, busy);
    for (int w = 0; w < 600 && busy !== 1'b0; w++) @(posedge clock_i);
    check_bit("busy", 1'b0, busy);
    repeat (4) @(posedge clock_i);
    // Random read: the protected attempt must have left the first byte alone
    address(adr);
    u_i2c_master_model.start();
    tx({4'hA, sel, 1'b1}, 1'b1);
    rx(d1, 1'b0);
    rx(8'hC3, 1'b1);
    u_i2c_master_model.stop();
    u_i2c_master_model.start();
    fork
      begin
        repeat (40) @(posedge clock_i);
        reset_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        reset_i <= 1'b0;
      end
      tx({4'hA, sel, 1'b0}, 1'b0);
    join
    u_i2c_master_model.stop();
    repeat (4) @(posedge clock_i);
    report_and_stop();
  end
endmodule
